/* File: core/port_pkg.sv */
// Shared types and constants for the general-purpose I/O port logic
// Assumes a single 20 MHz system clock and a synchronous active-low reset
package port_pkg;

	// -----------------------------------------------------------------
	// Widths and reset values
	// -----------------------------------------------------------------
	localparam int          PORT_W        = 8;            // Default pin count
	localparam logic [7:0]  LATCH_RST     = 8'h00;        // Latch value after reset
	localparam logic [7:0]  DIR_RST       = 8'hff;        // All pins input after reset
	localparam logic [7:0]  PULL_RST      = 8'h00;        // No pull-ups after reset
	localparam logic [1:0]  SYNC_RST      = 2'h0;         // Synchroniser tail reset

	// -----------------------------------------------------------------
	// Operation codes for read-modify-write access
	// -----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		OP_AND  = 3'h0,
		OP_OR   = 3'h1,
		OP_XOR  = 3'h2,
		OP_ADD  = 3'h3,
		OP_SUB  = 3'h4,
		OP_NOT  = 3'h5,
		OP_PASS = 3'h6
	} port_op_t;

	// -----------------------------------------------------------------
	// Access kinds from the processor side
	// -----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		ACC_IDLE  = 2'h0,
		ACC_WRITE = 2'h1,
		ACC_READ  = 2'h2,
		ACC_RMW   = 2'h3
	} port_acc_t;

	// Processor request bundle
	typedef struct packed
	{
		port_acc_t  acc;      // Kind of access
		port_op_t   op;       // Operation for read-modify-write
		logic [7:0] data;     // Write data or second operand
	} port_req_t;

endpackage

/* File: core/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
// Assumes the pin input is asynchronous to clk
`timescale 1ns/10ps
module pin_sync
	import port_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic pin_in,
	output logic      level_q
);

	// -----------------------------------------------------------------
	// Synchroniser stages
	// -----------------------------------------------------------------
	logic       meta_q;     // First stage, read only by the second
	logic [1:0] tail_q;     // Second and third stages

	// Shift the pin through three flip-flops
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			meta_q <= 1'b0;
			tail_q <= SYNC_RST;
		end
		else
		begin
			meta_q <= pin_in;
			tail_q <= {tail_q[0], meta_q};
		end
	end

	// Take a new level only when stages two and three agree
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			level_q <= 1'b0;
		else if (tail_q[0] == tail_q[1])
			level_q <= tail_q[1];
	end

endmodule

/* File: core/io_port_latch_logic.sv */
// General-purpose I/O port: output latch, direction and pull-up control
// Assumes requests come from processor logic on clk; pins are asynchronous
//
// Summary of operation
// - Output mode write stores latch, drives pins
// - Latch holds value until next write
// - System reset clears every output latch
// - Input mode write updates latch, pin undriven
// - Output mode read returns latch, unchanged
// - Input mode read returns sampled pins
// - Output mode operation uses latch, writes back
// - Input mode operation uses pins, writes latch
`timescale 1ns/10ps
module io_port_latch_logic
	import port_pkg::*;
#(
	parameter int WIDTH = PORT_W
)
(
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire port_req_t        req,
	input  wire logic [WIDTH-1:0] dir_wr_data,
	input  wire logic             dir_wr,
	input  wire logic [WIDTH-1:0] pull_wr_data,
	input  wire logic             pull_wr,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0]      pin_out,
	output logic [WIDTH-1:0]      pin_oe,
	output logic [WIDTH-1:0]      pin_pullup,
	output logic [WIDTH-1:0]      rd_data,
	output logic                  rd_valid,
	output logic [WIDTH-1:0]      direction_control_register,
	output logic [WIDTH-1:0]      pullup_option_register
);

	// -----------------------------------------------------------------
	// Elaboration checks
	// -----------------------------------------------------------------
	if (WIDTH < 1 || WIDTH > 8)
	begin : width_chk
		$error("WIDTH must be 1 to 8");
	end

	// -----------------------------------------------------------------
	// State and combinational values
	// -----------------------------------------------------------------
	logic [WIDTH-1:0] port_output_latch_group_q;   // Output latch
	logic [WIDTH-1:0] port_output_latch_group_d;   // Next latch value
	logic [WIDTH-1:0] pin_level;                   // Filtered pin levels
	logic [WIDTH-1:0] port_view;                   // Value seen by reads
	logic [WIDTH-1:0] operand_b;                   // Second operand
	logic [WIDTH-1:0] op_result;                   // Operation result
	logic             latch_we;                    // Latch write strobe

	// One synchroniser per pin
	for (genvar i = 0; i < WIDTH; i++)
	begin : sync_g
		pin_sync u_sync
		(
			.clk     (clk),
			.rst_b   (rst_b),
			.pin_in  (pin_in[i]),
			.level_q (pin_level[i])
		);
	end

	// -----------------------------------------------------------------
	// Read view and operation unit
	// -----------------------------------------------------------------

	// Output pins show latch, input pins show sampled level
	always_comb
	begin
		port_view = (direction_control_register & pin_level)
			| (~direction_control_register & port_output_latch_group_q);
	end

	// Arithmetic or logic on the per-pin view
	always_comb
	begin
		operand_b = req.data[WIDTH-1:0];
		case (req.op)
			OP_AND:  op_result = port_view & operand_b;
			OP_OR:   op_result = port_view | operand_b;
			OP_XOR:  op_result = port_view ^ operand_b;
			OP_ADD:  op_result = WIDTH'(port_view + operand_b);
			OP_SUB:  op_result = WIDTH'(port_view - operand_b);
			OP_NOT:  op_result = ~port_view;
			OP_PASS: op_result = port_view;
			default: op_result = port_view;
		endcase
	end

	// Latch next value: write takes data, operation takes result
	always_comb
	begin
		latch_we                  = 1'b0;
		port_output_latch_group_d = port_output_latch_group_q;
		case (req.acc)
			ACC_WRITE:
			begin
				latch_we                  = 1'b1;
				port_output_latch_group_d = req.data[WIDTH-1:0];
			end
			ACC_RMW:
			begin
				latch_we                  = 1'b1;
				port_output_latch_group_d = op_result;
			end
			default:
			begin
				latch_we = 1'b0;
			end
		endcase
	end

	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------

	// Output latch, cleared by reset
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			port_output_latch_group_q <= WIDTH'(LATCH_RST);
		else if (latch_we)
			port_output_latch_group_q <= port_output_latch_group_d;
	end

	// Direction bits, one per pin, 1 means input
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			direction_control_register <= WIDTH'(DIR_RST);
		else if (dir_wr)
			direction_control_register <= dir_wr_data;
	end

	// Pull-up option bits
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			pullup_option_register <= WIDTH'(PULL_RST);
		else if (pull_wr)
			pullup_option_register <= pull_wr_data;
	end

	// Pin drivers, registered from next-cycle state
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			pin_out    <= WIDTH'(LATCH_RST);
			pin_oe     <= ~WIDTH'(DIR_RST);
			pin_pullup <= WIDTH'(PULL_RST) & WIDTH'(DIR_RST);
		end
		else
		begin
			pin_out    <= port_output_latch_group_d;
			pin_oe     <= dir_wr ? ~dir_wr_data
				: ~direction_control_register;
			pin_pullup <= (pull_wr ? pull_wr_data : pullup_option_register)
				& (dir_wr ? dir_wr_data : direction_control_register);
		end
	end

	// Read data answers one cycle after a read
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			rd_data  <= '0;
			rd_valid <= 1'b0;
		end
		else
		begin
			rd_valid <= (req.acc == ACC_READ);
			if (req.acc == ACC_READ)
				rd_data <= port_view;
		end
	end

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	sequence read_req_s;
		req.acc == ACC_READ;
	endsequence

	sequence idle_s;
		req.acc == ACC_IDLE;
	endsequence

	reset_clear_a: assert property (@(posedge clk) !rst_b |=> port_output_latch_group_q == '0)
		else $error("latch not cleared by reset");

	write_store_a: assert property (@(posedge clk) disable iff (!rst_b)
		req.acc == ACC_WRITE |=> port_output_latch_group_q == $past(req.data[WIDTH-1:0]))
		else $error("write did not reach latch");

	latch_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		(read_req_s or idle_s) |=> $stable(port_output_latch_group_q))
		else $error("latch changed without write");

	pin_drive_a: assert property (@(posedge clk) disable iff (!rst_b)
		pin_out == port_output_latch_group_q)
		else $error("pins not showing latch");

	input_off_a: assert property (@(posedge clk) disable iff (!rst_b)
		!dir_wr ##1 1'b1 |-> (pin_oe & direction_control_register) == '0)
		else $error("driver on in input mode");

	read_view_a: assert property (@(posedge clk) disable iff (!rst_b)
		read_req_s |=> rd_valid && rd_data == $past(port_view))
		else $error("read data wrong");

	read_out_a: assert property (@(posedge clk) disable iff (!rst_b)
		read_req_s ##0 (direction_control_register == '0) |=>
		rd_data == $past(port_output_latch_group_q))
		else $error("output read not latch");

	read_in_a: assert property (@(posedge clk) disable iff (!rst_b)
		read_req_s ##0 (direction_control_register == '1) |=> rd_data == $past(pin_level))
		else $error("input read not pins");

	rmw_out_a: assert property (@(posedge clk) disable iff (!rst_b)
		req.acc == ACC_RMW && req.op == OP_OR && direction_control_register == '0 |=>
		port_output_latch_group_q ==
		($past(port_output_latch_group_q) | $past(req.data[WIDTH-1:0])))
		else $error("output operation wrong");

	rmw_in_a: assert property (@(posedge clk) disable iff (!rst_b)
		req.acc == ACC_RMW && req.op == OP_PASS && direction_control_register == '1 |=>
		port_output_latch_group_q == $past(pin_level))
		else $error("input operation wrong");

	pull_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
		!dir_wr && !pull_wr |=> pin_pullup ==
		($past(pullup_option_register) & $past(direction_control_register)))
		else $error("pull-up gating wrong");

endmodule

/* File: bench/pin_partner.sv */
// Behavioural model of the world outside the port pins
// Assumes the bench sets ext_val and ext_en; one clock, no pin contention
`timescale 1ns/10ps
module pin_partner
(
	input  wire logic       clk,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pin_pullup,
	input  wire logic [7:0] ext_val,
	input  wire logic [7:0] ext_en,
	output logic [7:0]      pin_lvl
);
	// -----------------------------------------------------------------
	// Wire resolution
	// -----------------------------------------------------------------
	logic [7:0] wobble_q = 8'h00;  // Floating level, pins 0, 2, 5 and 7 change every cycle

	// Floating pins 0, 2, 5 and 7 toggle each cycle; floating pins 1, 3, 4 and 6 stay low
	always_ff @(posedge clk)
		wobble_q <= ~wobble_q ^ 8'h5a;

	// Port driver wins, then external driver, then pull-up, else floating
	assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & (pin_pullup | wobble_q));
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the I/O port latch logic
// Assumes port_pkg and the design files are compiled first
`timescale 1ns/10ps
module tb_top
	import port_pkg::*;
;
	// -----------------------------------------------------------------
	// Signals and model state
	// -----------------------------------------------------------------
	logic       clk, rst_b, dir_wr, pull_wr, rd_valid;
	port_req_t  req;                            // Processor request
	logic [7:0] dir_wr_data, pull_wr_data, pin_in, pin_out, pin_oe;
	logic [7:0] pin_pullup, rd_data, dcr, por;
	logic [7:0] ext_val, ext_en;               // External driver
	logic [7:0] m_lat, m_dir, m_pull;          // Reference state
	int         n_mismatch, samples_checked, seed, i;

	io_port_latch_logic #(.WIDTH(8)) io_port_latch_logic_i (.clk(clk), .rst_b(rst_b),
		.req(req), .dir_wr_data(dir_wr_data), .dir_wr(dir_wr),
		.pull_wr_data(pull_wr_data), .pull_wr(pull_wr), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
		.rd_data(rd_data), .rd_valid(rd_valid),
		.direction_control_register(dcr), .pullup_option_register(por));
	pin_partner pin_partner_i (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup), .ext_val(ext_val), .ext_en(ext_en),
		.pin_lvl(pin_in));

	// Clock, 50 ns period
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Reference operation unit
	function automatic logic [7:0] alu(input port_op_t o, input logic [7:0] a, b);
		case (o)
			OP_AND:  return a & b;
			OP_OR:   return a | b;
			OP_XOR:  return a ^ b;
			OP_ADD:  return a + b;
			OP_SUB:  return a - b;
			OP_NOT:  return ~a;
			default: return a;
		endcase
	endfunction

	// Verdict and end of run
	task automatic wrap_up();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Set direction and pull-up bits, then let synchronisers settle
	task automatic cfg(input logic [7:0] d, input logic [7:0] p);
		@(posedge clk); #5;
		{dir_wr, dir_wr_data, pull_wr, pull_wr_data} = {1'b1, d, 1'b1, p};
		@(posedge clk); #5;
		{dir_wr, pull_wr} = 2'b00;
		{m_dir, m_pull} = {d, p};
		chk(pin_oe, ~d);
		chk(pin_pullup, p & d);
		chk(dcr, d);
		chk(por, p);
		repeat (6) @(posedge clk);
	endtask

	// Change the external drive and wait past the synchroniser
	task automatic set_ext(input logic [7:0] v, input logic [7:0] e);
		@(posedge clk); #5;
		{ext_val, ext_en} = {v, e};
		repeat (6) @(posedge clk);
	endtask

	// One access, checked against the reference one cycle later
	task automatic acc(input port_acc_t a, input port_op_t o, input logic [7:0] d);
		logic [7:0] v;
		v = (((ext_val & ext_en) | (~ext_en & m_pull)) & m_dir) | (m_lat & ~m_dir);
		@(posedge clk); #5;
		req = '{a, o, d};
		@(posedge clk); #5;
		req.acc = ACC_IDLE;
		if (a == ACC_WRITE)
			m_lat = d;
		if (a == ACC_RMW)
			m_lat = alu(o, v, d);
		chk(pin_out, m_lat);
		chk(pin_oe, ~m_dir);
		chk({7'h00, rd_valid}, {7'h00, a == ACC_READ});
		if (a == ACC_READ)
			chk(rd_data, v);
	endtask

	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial
	begin
		{n_mismatch, samples_checked, seed} = {32'd0, 32'd0, 32'd13124};
		{rst_b, dir_wr, pull_wr, dir_wr_data, pull_wr_data} = 19'h0;
		req = '{ACC_IDLE, OP_AND, 8'h00};
		{ext_val, ext_en, m_lat, m_dir, m_pull} = {8'h3c, 8'hff, 8'h00, 8'hff, 8'h00};
		repeat (5) @(posedge clk);
		#5 rst_b = 1'b1;
		chk(pin_out, 8'h00);
		chk(pin_oe, 8'h00);
		chk(dcr, 8'hff);
		// Let the pin synchronisers settle before the first read
		set_ext(8'h3c, 8'hff);
		// Input mode: writes and operations land in the latch only
		acc(ACC_WRITE, OP_AND, 8'ha5);
		acc(ACC_READ, OP_AND, 8'h00);
		for (i = 0; i < 7; i++)
			acc(ACC_RMW, port_op_t'(i), 8'($random(seed)));
		cfg(8'h00, 8'h00);
		// Output mode: latch drives pins and feeds reads and operations
		acc(ACC_WRITE, OP_AND, 8'h96);
		repeat (4) @(posedge clk);
		acc(ACC_READ, OP_AND, 8'h00);
		for (i = 0; i < 7; i++)
			acc(ACC_RMW, port_op_t'(i), 8'($random(seed)));
		// Random mixed directions and accesses
		for (i = 0; i < 24; i++)
		begin
			if (i % 6 == 0)
				cfg(8'($random(seed)), 8'h00);
			if (i % 6 == 0)
				set_ext(8'($random(seed)), 8'hff);
			acc(port_acc_t'(1 + $unsigned($random(seed)) % 3),
				port_op_t'($unsigned($random(seed)) % 7), 8'($random(seed)));
		end
		// Undriven input pins with pull-ups read high
		set_ext(8'h00, 8'h00);
		cfg(8'hf0, 8'hff);
		acc(ACC_READ, OP_AND, 8'h00);
		set_ext(8'h00, 8'hff);
		// Reset in mid-run clears a loaded latch
		// Software presets direction and latch as an alternate use would
		cfg(8'h00, 8'h00);
		acc(ACC_WRITE, OP_AND, 8'h5a);
		@(posedge clk); #5;
		rst_b = 1'b0;
		repeat (5) @(posedge clk);
		#5 rst_b = 1'b1;
		chk(pin_out, 8'h00);
		chk(pin_oe, 8'h00);
		chk(dcr, 8'hff);
		wrap_up();
	end
endmodule
